// ===== design/cmp_ctrl_pkg.sv
`default_nettype none
package cmp_ctrl_pkg;
	// Register port geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	// Register addresses on the local port
	localparam logic [2:0] ADDR_CTRL_STATUS = 3'h0;
	localparam logic [2:0] ADDR_PIN_DISABLE = 3'h1;
	localparam logic [2:0] ADDR_MUX_CTRL = 3'h2;
	localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
	localparam logic [2:0] ADDR_IRQ_CLEAR = 3'h4;
	localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h5;
	// Field positions in comparator_control_status
	localparam int BIT_POWER_OFF = 7;
	localparam int BIT_BANDGAP = 6;
	localparam int BIT_SYNC_OUT = 5;
	localparam int BIT_EVENT_FLAG = 4;
	localparam int BIT_IRQ_EN = 3;
	localparam int BIT_CAPTURE = 2;
	localparam int BIT_MODE_HI = 1;
	localparam int BIT_MODE_LO = 0;
	// Field positions in comparator_pin_input_disable
	localparam int BIT_NEG_OFF = 1;
	localparam int BIT_POS_OFF = 0;
	// Field position in the multiplexer control register
	localparam int BIT_MUX_EN = 6;
	// Field position in the interrupt status, clear and enable registers
	localparam int BIT_IRQ_CMP = 0;
	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] RESET_MODE = 2'h0;
	// Event mode encodings
	localparam logic [1:0] MODE_TOGGLE = 2'h0;
	localparam logic [1:0] MODE_RESERVED = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_RISE = 2'h3;
	// Synchroniser depth
	localparam int SYNC_STAGES = 2;
endpackage : cmp_ctrl_pkg
`default_nettype wire

// ===== design/cmp_sync.sv
`default_nettype none
module cmp_sync
	import cmp_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Raw level in, synchronised level out
	input wire logic raw_in,
	output logic sync_out
);
	logic [SYNC_STAGES-1:0] stage;
	logic [SYNC_STAGES-1:0] next_stage;

	// Shift chain; only the next stage reads each flop but the last, which drives sync_out
	always_comb begin
		next_stage = {stage[SYNC_STAGES-2:0], raw_in};
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stage <= '0;
		end else begin
			stage <= next_stage;
		end
	end

	assign sync_out = stage[SYNC_STAGES-1];
endmodule : cmp_sync
`default_nettype wire

// ===== design/analog_comparator_control.sv
// Operation
// - Raw comparator result is synchronised, one to two cycles, before readout.
// - Hardware sets the event flag on the transition chosen by event mode.
// - Interrupt requested only while flag, enable and global enable are set.
// - Taking the interrupt vector clears the event flag.
// - Writing one to the flag position clears the event flag.
// - Capture routing bit feeds synchronised output to the timer capture input.
// - Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - Mux enabled and converter off selects channel 0..7 as negative input.
// - Otherwise the dedicated negative pin feeds the negative input.
// - Input-disable bits turn off pin buffers and read that pin as zero.
// - Output is one when positive input exceeds negative input, else zero.
// - Bandgap select substitutes the internal reference for the positive pin.
//
// The implementer's own choices: the register offsets and the strobed register port.
`default_nettype none
module analog_comparator_control
	import cmp_ctrl_pkg::*;
#(
	parameter int LEVEL_W = 10,
	parameter int CHANNELS = 8,
	parameter int SEL_W = 3
) (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	// Digitised analog levels
	input wire logic [LEVEL_W-1:0] pos_pin_level,
	input wire logic [LEVEL_W-1:0] bandgap_level,
	input wire logic [LEVEL_W-1:0] neg_pin_level,
	input wire logic [CHANNELS*LEVEL_W-1:0] channel_levels,
	// Converter state
	input wire logic converter_enable,
	input wire logic [SEL_W-1:0] channel_select,
	// Processor interrupt handshake
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	output logic irq,
	// Timer capture front end
	output logic capture_route_active,
	output logic capture_input,
	// Comparator pins, digital side
	input wire logic pos_pin_digital,
	input wire logic neg_pin_digital,
	output logic pos_pin_read,
	output logic neg_pin_read,
	output logic pos_pin_buffer_on,
	output logic neg_pin_buffer_on,
	// Analog macro control
	output logic cmp_powered,
	output logic neg_from_mux
);
	logic cmp_power_off, next_cmp_power_off;
	logic cmp_bandgap_select, next_cmp_bandgap_select;
	logic cmp_irq_enable, next_cmp_irq_enable;
	logic cmp_capture_route, next_cmp_capture_route;
	logic [1:0] cmp_event_mode, next_cmp_event_mode;
	logic pos_pin_input_off, next_pos_pin_input_off;
	logic neg_pin_input_off, next_neg_pin_input_off;
	logic cmp_mux_enable, next_cmp_mux_enable;
	logic cmp_event_flag, next_cmp_event_flag;
	logic prev_output;
	logic [DATA_W-1:0] next_rdata;
	logic next_capture_input, next_pos_pin_read, next_neg_pin_read;
	logic next_neg_from_mux;
	logic [LEVEL_W-1:0] chan_level [CHANNELS];
	logic [LEVEL_W-1:0] pos_level, neg_level;
	logic use_mux, cmp_raw, cmp_sync_output;
	logic rise_pulse, fall_pulse, toggle_pulse, edge_event;
	logic wr_ctrl, wr_pins, wr_mux, wr_clear, wr_enable, flag_clear;

	// Unpack the converter channel levels
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
			assign chan_level[gi] = channel_levels[gi*LEVEL_W +: LEVEL_W];
		end
	endgenerate

	// Input selection and comparison; a powered-off macro reads low
	always_comb begin
		use_mux = cmp_mux_enable && !converter_enable;
		neg_level = use_mux ? chan_level[channel_select] : neg_pin_level;
		pos_level = cmp_bandgap_select ? bandgap_level : pos_pin_level;
		cmp_raw = !cmp_power_off && (pos_level > neg_level);
	end

	// Two flops: the raw result can change at any time
	cmp_sync u_sync (
		.clock(clock),
		.nrst(nrst),
		.raw_in(cmp_raw),
		.sync_out(cmp_sync_output)
	);

	// Edge pulses against last cycle's synchronised output
	always_comb begin
		rise_pulse = cmp_sync_output && !prev_output;
		fall_pulse = !cmp_sync_output && prev_output;
		toggle_pulse = rise_pulse || fall_pulse;
		case (cmp_event_mode)
			MODE_TOGGLE: edge_event = toggle_pulse;
			MODE_FALL: edge_event = fall_pulse;
			MODE_RISE: edge_event = rise_pulse;
			MODE_RESERVED: edge_event = 1'b0;
			default: edge_event = 1'b0;
		endcase
	end

	// Write decode
	always_comb begin
		wr_ctrl = wr && (addr == ADDR_CTRL_STATUS);
		wr_pins = wr && (addr == ADDR_PIN_DISABLE);
		wr_mux = wr && (addr == ADDR_MUX_CTRL);
		wr_clear = wr && (addr == ADDR_IRQ_CLEAR);
		wr_enable = wr && (addr == ADDR_IRQ_ENABLE);
		flag_clear = (wr_ctrl && wdata[BIT_EVENT_FLAG])
			|| (wr_clear && wdata[BIT_IRQ_CMP])
			|| irq_vector_taken;
	end

	// Next values of software registers and the event flag
	always_comb begin
		next_cmp_power_off = cmp_power_off;
		next_cmp_bandgap_select = cmp_bandgap_select;
		next_cmp_irq_enable = cmp_irq_enable;
		next_cmp_capture_route = cmp_capture_route;
		next_cmp_event_mode = cmp_event_mode;
		next_pos_pin_input_off = pos_pin_input_off;
		next_neg_pin_input_off = neg_pin_input_off;
		next_cmp_mux_enable = cmp_mux_enable;
		// Output bit has no storage, so writes to it vanish
		if (wr_ctrl) begin
			next_cmp_power_off = wdata[BIT_POWER_OFF];
			next_cmp_bandgap_select = wdata[BIT_BANDGAP];
			next_cmp_irq_enable = wdata[BIT_IRQ_EN];
			next_cmp_capture_route = wdata[BIT_CAPTURE];
			next_cmp_event_mode = {wdata[BIT_MODE_HI], wdata[BIT_MODE_LO]};
		end
		if (wr_enable) begin
			next_cmp_irq_enable = wdata[BIT_IRQ_CMP];
		end
		if (wr_pins) begin
			next_pos_pin_input_off = wdata[BIT_POS_OFF];
			next_neg_pin_input_off = wdata[BIT_NEG_OFF];
		end
		if (wr_mux) begin
			next_cmp_mux_enable = wdata[BIT_MUX_EN];
		end
		// A new event beats a clear in the same cycle
		if (edge_event) begin
			next_cmp_event_flag = 1'b1;
		end else if (flag_clear) begin
			next_cmp_event_flag = 1'b0;
		end else begin
			next_cmp_event_flag = cmp_event_flag;
		end
	end

	// Read mux and registered outputs
	always_comb begin
		next_rdata = RESET_BYTE;
		if (rd) begin
			case (addr)
				ADDR_CTRL_STATUS: begin
					next_rdata[BIT_POWER_OFF] = cmp_power_off;
					next_rdata[BIT_BANDGAP] = cmp_bandgap_select;
					next_rdata[BIT_SYNC_OUT] = cmp_sync_output;
					next_rdata[BIT_EVENT_FLAG] = cmp_event_flag;
					next_rdata[BIT_IRQ_EN] = cmp_irq_enable;
					next_rdata[BIT_CAPTURE] = cmp_capture_route;
					next_rdata[BIT_MODE_HI] = cmp_event_mode[1];
					next_rdata[BIT_MODE_LO] = cmp_event_mode[0];
				end
				ADDR_PIN_DISABLE: begin
					next_rdata[BIT_POS_OFF] = pos_pin_input_off;
					next_rdata[BIT_NEG_OFF] = neg_pin_input_off;
				end
				ADDR_MUX_CTRL: next_rdata[BIT_MUX_EN] = cmp_mux_enable;
				ADDR_IRQ_STATUS: next_rdata[BIT_IRQ_CMP] = cmp_event_flag;
				ADDR_IRQ_ENABLE: next_rdata[BIT_IRQ_CMP] = cmp_irq_enable;
				default: next_rdata = RESET_BYTE;
			endcase
		end
		next_capture_input = cmp_capture_route && cmp_sync_output;
		next_pos_pin_read = !pos_pin_input_off && pos_pin_digital;
		next_neg_pin_read = !neg_pin_input_off && neg_pin_digital;
		next_neg_from_mux = use_mux;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cmp_power_off <= 1'b0;
			cmp_bandgap_select <= 1'b0;
			cmp_irq_enable <= 1'b0;
			cmp_capture_route <= 1'b0;
			cmp_event_mode <= RESET_MODE;
			pos_pin_input_off <= 1'b0;
			neg_pin_input_off <= 1'b0;
			cmp_mux_enable <= 1'b0;
			cmp_event_flag <= 1'b0;
			prev_output <= 1'b0;
			rdata <= RESET_BYTE;
			capture_input <= 1'b0;
			pos_pin_read <= 1'b0;
			neg_pin_read <= 1'b0;
			neg_from_mux <= 1'b0;
		end else begin
			cmp_power_off <= next_cmp_power_off;
			cmp_bandgap_select <= next_cmp_bandgap_select;
			cmp_irq_enable <= next_cmp_irq_enable;
			cmp_capture_route <= next_cmp_capture_route;
			cmp_event_mode <= next_cmp_event_mode;
			pos_pin_input_off <= next_pos_pin_input_off;
			neg_pin_input_off <= next_neg_pin_input_off;
			cmp_mux_enable <= next_cmp_mux_enable;
			cmp_event_flag <= next_cmp_event_flag;
			prev_output <= cmp_sync_output;
			rdata <= next_rdata;
			capture_input <= next_capture_input;
			pos_pin_read <= next_pos_pin_read;
			neg_pin_read <= next_neg_pin_read;
			neg_from_mux <= next_neg_from_mux;
		end
	end

	// Level outputs straight from control state
	assign irq = cmp_event_flag && cmp_irq_enable && global_irq_enable;
	assign capture_route_active = cmp_capture_route;
	assign pos_pin_buffer_on = !pos_pin_input_off;
	assign neg_pin_buffer_on = !neg_pin_input_off;
	assign cmp_powered = !cmp_power_off;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	property p_sync_delay;
		##2 (cmp_sync_output == $past(cmp_raw, 2));
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("synchronised output does not lag raw by two");

	property p_event_sets;
		edge_event |=> cmp_event_flag;
	endproperty
	a_event_sets: assert property (p_event_sets)
		else $error("event did not set the flag");

	property p_fall_mode;
		$fell(cmp_sync_output) && (cmp_event_mode == MODE_FALL)
			|=> cmp_event_flag;
	endproperty
	a_fall_mode: assert property (p_fall_mode)
		else $error("falling edge missed in falling mode");

	property p_rise_mode;
		$rose(cmp_sync_output) && (cmp_event_mode == MODE_RISE)
			|=> cmp_event_flag;
	endproperty
	a_rise_mode: assert property (p_rise_mode)
		else $error("rising edge missed in rising mode");

	property p_reserved_quiet;
		(cmp_event_mode == MODE_RESERVED) && !cmp_event_flag
			&& !wr_ctrl |=> !cmp_event_flag;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet)
		else $error("reserved mode set the flag");

	property p_irq_gate;
		!cmp_irq_enable || !global_irq_enable |-> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt raised while disabled");

	property p_vector_clear;
		irq_vector_taken && !edge_event |=> !cmp_event_flag;
	endproperty
	a_vector_clear: assert property (p_vector_clear)
		else $error("vector did not clear the flag");

	property p_sw_clear;
		wr_ctrl && wdata[BIT_EVENT_FLAG] && !edge_event
			|=> !cmp_event_flag;
	endproperty
	a_sw_clear: assert property (p_sw_clear)
		else $error("writing one did not clear the flag");

	property p_zero_keeps;
		wr_ctrl && !wdata[BIT_EVENT_FLAG] && cmp_event_flag
			&& !irq_vector_taken && !wr_clear |=> cmp_event_flag;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps)
		else $error("writing zero changed the flag");

	property p_capture_off;
		!cmp_capture_route |=> !capture_input;
	endproperty
	a_capture_off: assert property (p_capture_off)
		else $error("capture driven with routing off");

	property p_mux_select;
		cmp_mux_enable && !converter_enable |=> neg_from_mux;
	endproperty
	a_mux_select: assert property (p_mux_select)
		else $error("mux not selected for negative input");

	property p_pin_select;
		!cmp_mux_enable || converter_enable |=> !neg_from_mux;
	endproperty
	a_pin_select: assert property (p_pin_select)
		else $error("dedicated pin not selected for negative input");

	property p_pin_zero;
		pos_pin_input_off |=> !pos_pin_read;
	endproperty
	a_pin_zero: assert property (p_pin_zero)
		else $error("disabled pin did not read zero");

	property p_neg_pin_zero;
		neg_pin_input_off |=> !neg_pin_read;
	endproperty
	a_neg_pin_zero: assert property (p_neg_pin_zero)
		else $error("disabled negative pin did not read zero");

	property p_read_flag;
		rd && (addr == ADDR_IRQ_STATUS)
			|=> rdata[BIT_IRQ_CMP] == $past(cmp_event_flag);
	endproperty
	a_read_flag: assert property (p_read_flag)
		else $error("status read does not show the flag");
endmodule : analog_comparator_control
`default_nettype wire

// ===== sim/tb_analog_comparator_control.sv
`default_nettype none
module tb_analog_comparator_control
	import cmp_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Design ports
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [9:0] pos_pin_level = '0;
	logic [9:0] bandgap_level = '0;
	logic [9:0] neg_pin_level = 10'h032;
	logic [79:0] channel_levels = '0;
	logic converter_enable = 1'b0;
	logic [2:0] channel_select = '0;
	logic global_irq_enable = 1'b0;
	logic irq_vector_taken = 1'b0;
	logic irq, capture_route_active, capture_input;
	logic pos_pin_digital = 1'b0;
	logic neg_pin_digital = 1'b0;
	logic pos_pin_read, neg_pin_read, pos_pin_buffer_on, neg_pin_buffer_on;
	logic cmp_powered, neg_from_mux;
	// Bench bookkeeping
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;

	always #5 clock = ~clock;

	analog_comparator_control i_dut (
		.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .pos_pin_level(pos_pin_level),
		.bandgap_level(bandgap_level), .neg_pin_level(neg_pin_level),
		.channel_levels(channel_levels),
		.converter_enable(converter_enable),
		.channel_select(channel_select),
		.global_irq_enable(global_irq_enable),
		.irq_vector_taken(irq_vector_taken), .irq(irq),
		.capture_route_active(capture_route_active),
		.capture_input(capture_input), .pos_pin_digital(pos_pin_digital),
		.neg_pin_digital(neg_pin_digital), .pos_pin_read(pos_pin_read),
		.neg_pin_read(neg_pin_read), .pos_pin_buffer_on(pos_pin_buffer_on),
		.neg_pin_buffer_on(neg_pin_buffer_on), .cmp_powered(cmp_powered),
		.neg_from_mux(neg_from_mux)
	);

	task automatic stop_test;
		if (err_total == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string name, input logic [7:0] exp,
			input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One-cycle write strobe, released on the next edge
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd_chk(input string name, input logic [2:0] a,
			input logic [7:0] exp, input logic [7:0] msk);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk(name, exp & msk, rdata & msk);
	endtask : rd_chk

	// Move the positive level and let synchroniser and flag settle
	task automatic set_pos(input logic [9:0] v);
		@(posedge clock);
		pos_pin_level <= v;
		repeat (5) @(posedge clock);
		#1;
	endtask : set_pos

	task automatic pulse_vector;
		@(posedge clock);
		irq_vector_taken <= 1'b1;
		@(posedge clock);
		irq_vector_taken <= 1'b0;
		@(posedge clock);
		#1;
	endtask : pulse_vector

	// Hang guard, well above the length of the sequence below
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		logic [1:0] m;
		for (int k = 0; k < 8; k++) begin
			channel_levels[k*10 +: 10] = 10'(k * 25 + 10);
		end
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		#1;
		// Reset state and unmapped or write-only places
		chk("buffers", 8'h03, {6'h0, pos_pin_buffer_on, neg_pin_buffer_on});
		chk("powered", 8'h01, {7'h0, cmp_powered});
		rd_chk("ctrl", ADDR_CTRL_STATUS, 8'h00, 8'hff);
		rd_chk("pins", ADDR_PIN_DISABLE, 8'h00, 8'hff);
		rd_chk("clear", ADDR_IRQ_CLEAR, 8'h00, 8'hff);
		rd_chk("unmapped", 3'h6, 8'h00, 8'hff);
		// Synchronised output, toggle event, write one and write zero
		set_pos(10'h064);
		rd_chk("ctrl", ADDR_CTRL_STATUS, 8'h30, 8'hff);
		wr_reg(ADDR_CTRL_STATUS, 8'h20);
		rd_chk("ctrl", ADDR_CTRL_STATUS, 8'h30, 8'hff);
		wr_reg(ADDR_CTRL_STATUS, 8'h10);
		rd_chk("ctrl", ADDR_CTRL_STATUS, 8'h20, 8'hff);
		set_pos(10'h000);
		// Every event mode against a rise and a fall
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr_reg(ADDR_CTRL_STATUS, {6'h04, m});
			set_pos(10'h064);
			rd_chk("rise", ADDR_IRQ_STATUS, {7'h0, (m == 0 || m == 3)},
				8'hff);
			wr_reg(ADDR_IRQ_CLEAR, 8'h01);
			set_pos(10'h000);
			rd_chk("fall", ADDR_IRQ_STATUS, {7'h0, (m == 0 || m == 2)},
				8'hff);
			wr_reg(ADDR_IRQ_CLEAR, 8'h01);
		end
		// Interrupt gating and vector clear
		wr_reg(ADDR_IRQ_ENABLE, 8'h01);
		set_pos(10'h064);
		chk("irq", 8'h00, {7'h0, irq});
		@(posedge clock);
		global_irq_enable <= 1'b1;
		#1;
		chk("irq", 8'h01, {7'h0, irq});
		rd_chk("ctrl", ADDR_CTRL_STATUS, 8'h3b, 8'hff);
		pulse_vector();
		chk("irq", 8'h00, {7'h0, irq});
		rd_chk("status", ADDR_IRQ_STATUS, 8'h00, 8'hff);
		wr_reg(ADDR_IRQ_ENABLE, 8'h00);
		set_pos(10'h000);
		set_pos(10'h064);
		chk("irq", 8'h00, {7'h0, irq});
		rd_chk("ctrl", ADDR_CTRL_STATUS, 8'h33, 8'hff);
		wr_reg(ADDR_IRQ_CLEAR, 8'h01);
		// Capture routing
		wr_reg(ADDR_CTRL_STATUS, 8'h07);
		repeat (2) @(posedge clock);
		#1;
		chk("route", 8'h01, {7'h0, capture_route_active});
		chk("capture", 8'h01, {7'h0, capture_input});
		set_pos(10'h000);
		chk("capture", 8'h00, {7'h0, capture_input});
		wr_reg(ADDR_CTRL_STATUS, 8'h13);
		#1;
		chk("route", 8'h00, {7'h0, capture_route_active});
		// Internal reference and power off
		@(posedge clock);
		bandgap_level <= 10'h0c8;
		wr_reg(ADDR_CTRL_STATUS, 8'h40);
		repeat (4) @(posedge clock);
		rd_chk("bandgap", ADDR_CTRL_STATUS, 8'h20, 8'h20);
		wr_reg(ADDR_CTRL_STATUS, 8'hc0);
		repeat (4) @(posedge clock);
		#1;
		chk("powered", 8'h00, {7'h0, cmp_powered});
		rd_chk("power_off", ADDR_CTRL_STATUS, 8'h00, 8'h20);
		wr_reg(ADDR_CTRL_STATUS, 8'h10);
		// Negative input from the converter channels
		pos_pin_level <= 10'h064;
		neg_pin_level <= 10'h0c8;
		wr_reg(ADDR_MUX_CTRL, 8'hff);
		rd_chk("mux", ADDR_MUX_CTRL, 8'h40, 8'hff);
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			channel_select <= 3'(k);
			repeat (5) @(posedge clock);
			rd_chk("channel", ADDR_CTRL_STATUS, (k <= 3) ? 8'h20 : 8'h00,
				8'h20);
			chk("from_mux", 8'h01, {7'h0, neg_from_mux});
		end
		@(posedge clock);
		channel_select <= 3'h0;
		converter_enable <= 1'b1;
		repeat (5) @(posedge clock);
		rd_chk("neg_pin", ADDR_CTRL_STATUS, 8'h00, 8'h20);
		chk("from_mux", 8'h00, {7'h0, neg_from_mux});
		// Digital input disable
		@(posedge clock);
		pos_pin_digital <= 1'b1;
		neg_pin_digital <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk("pin_reads", 8'h03, {6'h0, pos_pin_read, neg_pin_read});
		wr_reg(ADDR_PIN_DISABLE, 8'hff);
		rd_chk("pins", ADDR_PIN_DISABLE, 8'h03, 8'hff);
		repeat (2) @(posedge clock);
		#1;
		chk("pin_reads", 8'h00, {6'h0, pos_pin_read, neg_pin_read});
		chk("buffers", 8'h00,
			{6'h0, pos_pin_buffer_on, neg_pin_buffer_on});
		stop_test();
	end
endmodule : tb_analog_comparator_control
`default_nettype wire
